// *** otp_fuse_pkg.sv ***
// What this block does
// - raw read-back enable high: reads show uncorrected latch values
// - correction off or no error: shadow equals raw fuse contents
// - correction on, single error: shadow takes the corrected value
// - ten bank control registers, one per fuse bank
// - bit 0 selects latch (0) or shadow (1) for the bank output
// - bit 1 enables bank programming; host sets it only at 8.25 V
// - bit 2 rising while bias on loads the digital latch
// - bit 3 enables analog fuse cell bias
// - correction is off after reset
// - correct at most one bit per bank; double errors only reported
// - single error sets bank single flag and correction interrupt
// - double error leaves data, sets bank double flag and interrupt
// - single flags banks 1-5 at 0x8a, 6-10 at 0x8b, reset 0
// - double flags banks 1-5 at 0x8c, 6-10 at 0x8d, reset 0
// - correction interrupt bit readable at functional address 0x0e
// - interrupts masked after reset; host unmasks after programming
// - latch-reload request refreshes every latch from its fuse cell
// - shadow-reload copies raw or corrected values into shadows
// - reload passes load fuses only while xor of redundant load bits is 1; the bit 2 strobe loads regardless
package otp_fuse_pkg;
	localparam int num_banks  = 10;
	localparam int half_banks = 5;
	localparam int data_w     = 20;
	localparam int check_w    = 6;

	// register pages
	localparam logic [1:0] page_func = 2'h0;
	localparam logic [1:0] page_ext1 = 2'h1;
	localparam logic [1:0] page_ext2 = 2'h2;

	// offsets
	localparam logic [7:0] off_int_status = 8'h0e;
	localparam logic [7:0] off_int_mask   = 8'h0f;
	localparam logic [7:0] off_raw_read   = 8'h80;
	localparam logic [7:0] off_se_lo      = 8'h8a;
	localparam logic [7:0] off_se_hi      = 8'h8b;
	localparam logic [7:0] off_de_lo      = 8'h8c;
	localparam logic [7:0] off_de_hi      = 8'h8d;
	localparam logic [7:0] off_ctl_base   = 8'hc0;

	// field positions
	localparam int raw_en_bit = 0;
	localparam int int_bit    = 0;
	localparam int ctl_w      = 4;

	// reset values
	localparam logic       raw_en_rst   = 1'b0;
	localparam logic [3:0] ctl_rst      = 4'h0;
	localparam logic       int_mask_rst = 1'b1;
	localparam logic [7:0] rdata_rst    = 8'h00;

	// check code of each data bit; check bit j alone codes as 1<<j
	localparam logic [5:0] ecc_code [0:19] = '{
		6'h07, 6'h0b, 6'h0d, 6'h0e, 6'h13, 6'h15, 6'h16, 6'h19, 6'h1a, 6'h1c,
		6'h23, 6'h25, 6'h26, 6'h29, 6'h2a, 6'h2c, 6'h31, 6'h32, 6'h34, 6'h38};

	typedef struct packed {
		logic bias_en;
		logic load_strobe;
		logic program_en;
		logic bypass_sel;
	} bank_ctl_t;

	typedef struct packed {
		logic [check_w-1:0] check;
		logic [data_w-1:0]  data;
	} fuse_word_t;

	typedef struct packed {
		logic [data_w-1:0] data;
		logic              single_err;
		logic              double_err;
	} ecc_result_t;
endpackage

// *** otp_bank_secded.sv ***
`timescale 1ns/1ps
module otp_bank_secded (
	input  otp_fuse_pkg::fuse_word_t  raw_i,
	input  wire logic                 ecc_en_i,
	output otp_fuse_pkg::ecc_result_t result_o
);
	// ==========================================
	// check bits over the data word
	function automatic logic [5:0] calc_check(input logic [19:0] d);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < otp_fuse_pkg::data_w; i++) begin
			if (d[i]) begin
				c = c ^ otp_fuse_pkg::ecc_code[i];
			end
		end
		return c;
	endfunction

	// ==========================================
	// syndrome decode
	always_comb begin
		logic [5:0]  syn;
		logic [19:0] fix;
		syn = calc_check(raw_i.data) ^ raw_i.check;
		fix = 20'h00000;
		for (int i = 0; i < otp_fuse_pkg::data_w; i++) begin
			if (syn == otp_fuse_pkg::ecc_code[i]) begin
				fix[i] = 1'b1;
			end
		end
		result_o.data       = raw_i.data;
		result_o.single_err = 1'b0;
		result_o.double_err = 1'b0;
		if (ecc_en_i && syn != 6'h00) begin
			if (fix != 20'h00000) begin
				result_o.data       = raw_i.data ^ fix;
				result_o.single_err = 1'b1;
			end else if ($onehot(syn)) begin
				result_o.single_err = 1'b1; // check bit itself wrong
			end else begin
				result_o.double_err = 1'b1;
			end
		end
	end
endmodule

// *** otp_bank_latch.sv ***
`timescale 1ns/1ps
module otp_bank_latch (
	input  wire logic                mclk_i,
	input  wire logic                rst_b_i,
	input  otp_fuse_pkg::fuse_word_t cell_i,
	input  wire logic                capture_i,
	output otp_fuse_pkg::fuse_word_t word_o
);
	// ==========================================
	// digital copy of the analog cell state
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_o <= '0;
		end else if (capture_i) begin
			word_o <= cell_i;
		end
	end
endmodule

// *** otp_fuse_bank_ecc_control.sv ***
`timescale 1ns/1ps
module otp_fuse_bank_ecc_control (
	input  wire logic                                       mclk_i,
	input  wire logic                                       rst_b_i,
	// register port
	input  wire logic [1:0]                                 reg_page_i,
	input  wire logic [7:0]                                 reg_addr_i,
	input  wire logic                                       reg_wr_i,
	input  wire logic                                       reg_rd_i,
	input  wire logic [7:0]                                 reg_wdata_i,
	output logic [7:0]                                      reg_rdata_o,
	output logic                                            reg_rvalid_o,
	// fuse array side
	input  otp_fuse_pkg::fuse_word_t [otp_fuse_pkg::num_banks-1:0] fuse_cell_i,
	output logic [otp_fuse_pkg::num_banks-1:0]              bank_bias_en_o,
	output logic [otp_fuse_pkg::num_banks-1:0]              bank_program_en_o,
	output logic [otp_fuse_pkg::num_banks-1:0]              bank_load_strobe_o,
	// correction enables and load permit
	input  wire logic [otp_fuse_pkg::num_banks-1:0]         ecc_enable_i,
	input  wire logic [2:0]                                 redundant_load_bits_i,
	// reload request
	input  wire logic                                       reload_start_i,
	input  wire logic                                       reload_fuse_latch_i,
	input  wire logic                                       reload_shadow_i,
	output logic                                            reload_done_o,
	// configuration read-back
	input  wire logic [3:0]                                 cfg_rd_bank_i,
	output logic [otp_fuse_pkg::data_w-1:0]                 cfg_rd_data_o,
	output logic [otp_fuse_pkg::num_banks-1:0][otp_fuse_pkg::data_w-1:0] config_o,
	// correction interrupt
	output logic                                            ecc_int_o,
	output logic                                            irq_o
);
	// ==========================================
	// declarations
	typedef enum logic [1:0] {
		st_idle,
		st_latch,
		st_shadow
	} load_state_t;

	load_state_t                                          state_q;
	logic                                                 por_pend_q;
	logic                                                 latch_req_q;
	logic                                                 shadow_req_q;
	logic                                                 done_q;
	logic                                                 raw_en_q;
	logic                                                 int_q;
	logic                                                 int_mask_q;
	logic [otp_fuse_pkg::num_banks-1:0]                   se_q;
	logic [otp_fuse_pkg::num_banks-1:0]                   de_q;
	otp_fuse_pkg::bank_ctl_t [otp_fuse_pkg::num_banks-1:0] ctl_q;
	logic [otp_fuse_pkg::num_banks-1:0]                   strobe_prev_q;
	logic [otp_fuse_pkg::num_banks-1:0][otp_fuse_pkg::data_w-1:0] shadow_q;
	logic [otp_fuse_pkg::num_banks-1:0][otp_fuse_pkg::data_w-1:0] config_q;
	logic [otp_fuse_pkg::data_w-1:0]                      cfg_rd_q;
	logic [7:0]                                           rdata_q;
	logic                                                 rvalid_q;
	logic [otp_fuse_pkg::num_banks-1:0]                   ecc_en_q;
	otp_fuse_pkg::fuse_word_t  [otp_fuse_pkg::num_banks-1:0] latch_word;
	otp_fuse_pkg::ecc_result_t [otp_fuse_pkg::num_banks-1:0] ecc_res;
	logic [otp_fuse_pkg::num_banks-1:0]                   capture;
	logic [otp_fuse_pkg::num_banks-1:0]                   se_new;
	logic [otp_fuse_pkg::num_banks-1:0]                   de_new;
	logic                                                 load_permit;
	logic                                                 shadow_load;
	logic                                                 int_clear;

	// ==========================================
	// address decode helpers
	// shared by the write and read paths so both see one map
	function automatic logic reg_hit(
		input logic [1:0] page,
		input logic [7:0] addr,
		input logic [1:0] want_page,
		input logic [7:0] want_addr
	);
		return (page == want_page) && (addr == want_addr);
	endfunction

	// bank index of a control register, num_banks when none
	function automatic logic [3:0] ctl_index(
		input logic [1:0] page,
		input logic [7:0] addr
	);
		logic [7:0] rel;
		rel = addr - otp_fuse_pkg::off_ctl_base;
		if (page == otp_fuse_pkg::page_ext2 &&
		    addr >= otp_fuse_pkg::off_ctl_base &&
		    rel < 8'(otp_fuse_pkg::num_banks)) begin
			return rel[3:0];
		end
		return 4'(otp_fuse_pkg::num_banks);
	endfunction

	// ==========================================
	// fuse load permit
	// xor of redundant bits
	assign load_permit = ^redundant_load_bits_i;

	// ==========================================
	// load sequencer
	// one pass: latch refresh, then shadow copy and flag update
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= st_idle;
		end else begin
			unique case (state_q)
				st_idle: begin
					if (reload_start_i || por_pend_q) begin
						state_q <= st_latch;
					end
				end
				st_latch: begin
					state_q <= st_shadow;
				end
				st_shadow: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// power-on load runs once after reset release
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			por_pend_q <= 1'b1;
		end else if (state_q == st_idle) begin
			por_pend_q <= 1'b0;
		end
	end

	// request bits and correction enables held for the whole pass
	// correction off out of reset
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			latch_req_q  <= 1'b0;
			shadow_req_q <= 1'b0;
			ecc_en_q     <= '0;
		end else if (state_q == st_idle) begin
			latch_req_q  <= por_pend_q | reload_fuse_latch_i;
			shadow_req_q <= por_pend_q | reload_shadow_i;
			ecc_en_q     <= ecc_enable_i;
		end
	end

	// done pulse one cycle after the shadow step
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (state_q == st_shadow);
		end
	end
	assign reload_done_o = done_q;
	// shadow and flags update only when the permit holds
	assign shadow_load = (state_q == st_shadow) && shadow_req_q && load_permit;

	// ==========================================
	// per-bank latch and correction
	generate
		for (genvar b = 0; b < otp_fuse_pkg::num_banks; b++) begin : g_bank
			assign capture[b] = (ctl_q[b].load_strobe && !strobe_prev_q[b] &&
			                     ctl_q[b].bias_en) ||
			                    ((state_q == st_latch) && latch_req_q && load_permit);

			otp_bank_latch u_latch (
				.mclk_i    (mclk_i),
				.rst_b_i   (rst_b_i),
				.cell_i    (fuse_cell_i[b]),
				.capture_i (capture[b]),
				.word_o    (latch_word[b])
			);

			otp_bank_secded u_secded (
				.raw_i     (latch_word[b]),
				.ecc_en_i  (ecc_en_q[b]),
				.result_o  (ecc_res[b])
			);

			assign se_new[b] = ecc_res[b].single_err;
			assign de_new[b] = ecc_res[b].double_err;
		end
	endgenerate

	// strobe history for edge detection
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strobe_prev_q <= '0;
		end else begin
			for (int b = 0; b < otp_fuse_pkg::num_banks; b++) begin
				strobe_prev_q[b] <= ctl_q[b].load_strobe;
			end
		end
	end

	// ==========================================
	// configuration shadows
	// raw or corrected copy
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shadow_q <= '0;
		end else if (shadow_load) begin
			for (int b = 0; b < otp_fuse_pkg::num_banks; b++) begin
				shadow_q[b] <= ecc_res[b].data;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			config_q <= '0;
		end else begin
			for (int b = 0; b < otp_fuse_pkg::num_banks; b++) begin
				config_q[b] <= ctl_q[b].bypass_sel ? shadow_q[b] : latch_word[b].data;
			end
		end
	end
	assign config_o = config_q;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_rd_q <= '0;
		end else if (cfg_rd_bank_i < 4'(otp_fuse_pkg::num_banks)) begin
			cfg_rd_q <= raw_en_q ? latch_word[cfg_rd_bank_i].data
			                     : shadow_q[cfg_rd_bank_i];
		end else begin
			cfg_rd_q <= '0;
		end
	end
	assign cfg_rd_data_o = cfg_rd_q;

	// ==========================================
	// error flags
	// clear and refill each load
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			se_q <= '0;
			de_q <= '0;
		end else if (shadow_load) begin
			se_q <= se_new;
			de_q <= de_new;
		end
	end

	// ==========================================
	// correction interrupt
	assign int_clear = reg_wr_i && reg_wdata_i[otp_fuse_pkg::int_bit] &&
	                   reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_func,
	                           otp_fuse_pkg::off_int_status);

	// set on any error; set beats a same-cycle clear
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_q <= 1'b0;
		end else if (shadow_load && ((se_new | de_new) != '0)) begin
			int_q <= 1'b1;
		end else if (int_clear) begin
			int_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			int_mask_q <= otp_fuse_pkg::int_mask_rst;
		end else if (reg_wr_i && reg_hit(reg_page_i, reg_addr_i,
		             otp_fuse_pkg::page_func, otp_fuse_pkg::off_int_mask)) begin
			int_mask_q <= reg_wdata_i[otp_fuse_pkg::int_bit];
		end
	end
	assign ecc_int_o = int_q;
	assign irq_o     = int_q & ~int_mask_q;

	// ==========================================
	// writable registers
	// raw read-back enable
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			raw_en_q <= otp_fuse_pkg::raw_en_rst;
		end else if (reg_wr_i && reg_hit(reg_page_i, reg_addr_i,
		             otp_fuse_pkg::page_ext1, otp_fuse_pkg::off_raw_read)) begin
			raw_en_q <= reg_wdata_i[otp_fuse_pkg::raw_en_bit];
		end
	end

	// upper four bits dropped on write
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int b = 0; b < otp_fuse_pkg::num_banks; b++) begin
				ctl_q[b] <= otp_fuse_pkg::ctl_rst;
			end
		end else if (reg_wr_i &&
		             ctl_index(reg_page_i, reg_addr_i) < 4'(otp_fuse_pkg::num_banks)) begin
			ctl_q[ctl_index(reg_page_i, reg_addr_i)] <= reg_wdata_i[otp_fuse_pkg::ctl_w-1:0];
		end
	end

	// program enable, bias, to the analog cells
	always_comb begin
		for (int b = 0; b < otp_fuse_pkg::num_banks; b++) begin
			bank_bias_en_o[b]     = ctl_q[b].bias_en;
			bank_program_en_o[b]  = ctl_q[b].program_en;
			bank_load_strobe_o[b] = ctl_q[b].load_strobe;
		end
	end

	// ==========================================
	// read path
	// registered one cycle later; unmapped reads give zero
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= otp_fuse_pkg::rdata_rst;
		end else if (reg_rd_i) begin
			rdata_q <= otp_fuse_pkg::rdata_rst;
			// interrupt bit on the functional page
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_func,
			            otp_fuse_pkg::off_int_status)) begin
				rdata_q <= {7'h00, int_q};
			end
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_func,
			            otp_fuse_pkg::off_int_mask)) begin
				rdata_q <= {7'h00, int_mask_q};
			end
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_ext1,
			            otp_fuse_pkg::off_raw_read)) begin
				rdata_q <= {7'h00, raw_en_q};
			end
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_ext1,
			            otp_fuse_pkg::off_se_lo)) begin
				rdata_q <= {3'h0, se_q[otp_fuse_pkg::half_banks-1:0]};
			end
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_ext1,
			            otp_fuse_pkg::off_se_hi)) begin
				rdata_q <= {3'h0, se_q[otp_fuse_pkg::num_banks-1:otp_fuse_pkg::half_banks]};
			end
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_ext1,
			            otp_fuse_pkg::off_de_lo)) begin
				rdata_q <= {3'h0, de_q[otp_fuse_pkg::half_banks-1:0]};
			end
			if (reg_hit(reg_page_i, reg_addr_i, otp_fuse_pkg::page_ext1,
			            otp_fuse_pkg::off_de_hi)) begin
				rdata_q <= {3'h0, de_q[otp_fuse_pkg::num_banks-1:otp_fuse_pkg::half_banks]};
			end
			if (ctl_index(reg_page_i, reg_addr_i) < 4'(otp_fuse_pkg::num_banks)) begin
				rdata_q <= {4'h0, ctl_q[ctl_index(reg_page_i, reg_addr_i)]};
			end
		end
	end

	// read strobe echoed as a one-cycle valid
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_rd_i;
		end
	end
	assign reg_rdata_o  = rdata_q;
	assign reg_rvalid_o = rvalid_q;
endmodule

// *** otp_fuse_monitor.sv ***
`timescale 1ns/1ps
// ==========
// port checker
module otp_fuse_monitor (
	input wire logic        mclk_i,
	input wire logic        rst_b_i,
	input wire logic [1:0]  reg_page_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        reg_rvalid_o,
	input wire logic [9:0]  bank_bias_en_o,
	input wire logic [9:0]  bank_program_en_o,
	input wire logic        reload_done_o,
	input wire logic [3:0]  cfg_rd_bank_i,
	input wire logic [19:0] cfg_rd_data_o,
	input wire logic        ecc_int_o,
	input wire logic        irq_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);

	// register port answers and reserved bits
	property p_rvalid;
		reg_rd_i |=> reg_rvalid_o;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_raw_rsv;
		reg_rd_i && reg_page_i == 2'h1 && reg_addr_i == 8'h80 |=> reg_rdata_o[7:1] == 7'h00;
	endproperty
	a_raw_rsv: assert property (p_raw_rsv) else $error("read enable upper bits set");
	property p_ctl_rsv;
		reg_rd_i && reg_page_i == 2'h2 && reg_addr_i[7:4] == 4'hc |=> reg_rdata_o[7:4] == 4'h0;
	endproperty
	a_ctl_rsv: assert property (p_ctl_rsv) else $error("control upper bits set");
	property p_flag_rsv;
		reg_rd_i && reg_page_i == 2'h1 && reg_addr_i >= 8'h8a && reg_addr_i <= 8'h8d |=> reg_rdata_o[7:5] == 3'h0;
	endproperty
	a_flag_rsv: assert property (p_flag_rsv) else $error("flag upper bits set");

	// control bits reach the bank pins, and only on a write
	property p_bias;
		reg_wr_i && reg_page_i == 2'h2 && reg_addr_i == 8'hc0
		|=> bank_bias_en_o[0] == $past(reg_wdata_i[3]) && bank_program_en_o[0] == $past(reg_wdata_i[1]);
	endproperty
	a_bias: assert property (p_bias) else $error("bank 1 pins differ from write");
	property p_ctl_hold;
		!(reg_wr_i && reg_page_i == 2'h2) |=> $stable(bank_bias_en_o) && $stable(bank_program_en_o);
	endproperty
	a_ctl_hold: assert property (p_ctl_hold) else $error("bank pins moved without write");

	// interrupt only from a load, irq only while status is set
	property p_irq_mask;
		irq_o |-> ecc_int_o;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq without status");
	property p_int_rise;
		$rose(ecc_int_o) |-> reload_done_o;
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("status set outside load");
	property p_done_pulse;
		reload_done_o |=> !reload_done_o;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_bank_range;
		cfg_rd_bank_i > 4'h9 ##1 cfg_rd_bank_i > 4'h9 |-> cfg_rd_data_o == 20'h00000;
	endproperty
	a_bank_range: assert property (p_bank_range) else $error("bad bank read not zero");
endmodule

bind otp_fuse_bank_ecc_control otp_fuse_monitor i_mon (
	.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .bank_bias_en_o(bank_bias_en_o), .bank_program_en_o(bank_program_en_o),
	.reload_done_o(reload_done_o), .cfg_rd_bank_i(cfg_rd_bank_i), .cfg_rd_data_o(cfg_rd_data_o),
	.ecc_int_o(ecc_int_o), .irq_o(irq_o));

// *** fuse_array_model.sv ***
`timescale 1ns/1ps
// ==========
// analog fuse cells
module fuse_array_model (
	input  wire logic [otp_fuse_pkg::num_banks-1:0]              bias_en_i,
	output otp_fuse_pkg::fuse_word_t [otp_fuse_pkg::num_banks-1:0] cell_o
);
	// blank cells read zero; a blank word is a valid code word
	initial begin
		cell_o = '0;
	end
	task put(input int b, input otp_fuse_pkg::fuse_word_t w);
		cell_o[b] = w;
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
// ==========
// bench
module tb_top;
	localparam int nb = otp_fuse_pkg::num_banks;
	logic                                  mclk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
	logic                                  reload_start_i, reload_fuse_latch_i, reload_shadow_i;
	logic                                  reload_done_o, ecc_int_o, irq_o;
	logic [1:0]                            reg_page_i;
	logic [2:0]                            redundant_load_bits_i;
	logic [3:0]                            cfg_rd_bank_i;
	logic [7:0]                            reg_addr_i, reg_wdata_i, reg_rdata_o, v;
	logic [nb-1:0]                         bias_o, prog_o, strobe_o, ecc_enable_i, se, de;
	logic [19:0]                           cfg_rd_data_o, dat [nb], raw [nb];
	logic [nb-1:0][19:0]                   config_o;
	otp_fuse_pkg::fuse_word_t [nb-1:0]     fuse_cell;
	otp_fuse_pkg::fuse_word_t              w;
	int                                    n_mismatch, total_checks, kind [nb];

	fuse_array_model i_cells (.bias_en_i(bias_o), .cell_o(fuse_cell));
	otp_fuse_bank_ecc_control i_dut (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .fuse_cell_i(fuse_cell), .bank_bias_en_o(bias_o),
		.bank_program_en_o(prog_o), .bank_load_strobe_o(strobe_o), .ecc_enable_i(ecc_enable_i),
		.redundant_load_bits_i(redundant_load_bits_i), .reload_start_i(reload_start_i),
		.reload_fuse_latch_i(reload_fuse_latch_i), .reload_shadow_i(reload_shadow_i),
		.reload_done_o(reload_done_o), .cfg_rd_bank_i(cfg_rd_bank_i), .cfg_rd_data_o(cfg_rd_data_o),
		.config_o(config_o), .ecc_int_o(ecc_int_o), .irq_o(irq_o));

	// 100 ns clock
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// inputs always move 1 ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	// a spare cycle after each strobe so no strobe is set twice in one step
	task wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
		reg_page_i = p;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask
	task rchk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] exp);
		reg_page_i = p;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		chk("rvalid", 1, reg_rvalid_o);
		chk($sformatf("reg %0h:%h", p, a), exp, reg_rdata_o);
		tick(1);
	endtask
	task wait_done;
		int i;
		for (i = 0; i < 20 && reload_done_o !== 1'b1; i++)
			tick(1);
		if (i == 20) begin
			n_mismatch++;
			$display("[FAIL] reload_done expected 1 seen 0");
			stop_test();
		end else begin
			tick(1);
		end
	endtask
	task reload(input logic [2:0] perm);
		redundant_load_bits_i = perm; // settled before the pass starts
		reload_start_i = 1'b1;
		tick(1);
		reload_start_i = 1'b0;
		wait_done();
	endtask
	// flag bytes as the host sees them
	task flags_chk(input logic [nb-1:0] s, input logic [nb-1:0] d);
		rchk(2'h1, 8'h8a, {3'h0, s[4:0]});
		rchk(2'h1, 8'h8b, {3'h0, s[9:5]});
		rchk(2'h1, 8'h8c, {3'h0, d[4:0]});
		rchk(2'h1, 8'h8d, {3'h0, d[9:5]});
	endtask
	task cfg_chk(input logic use_raw);
		for (int b = 0; b < nb; b++) begin
			cfg_rd_bank_i = 4'(b);
			tick(2);
			chk("cfg data", use_raw ? raw[b] : dat[b], cfg_rd_data_o);
		end
		cfg_rd_bank_i = 4'hf;
		tick(2);
		chk("cfg bad bank", 0, cfg_rd_data_o);
	endtask
	function automatic otp_fuse_pkg::fuse_word_t enc(input logic [19:0] d);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < 20; i++)
			if (d[i])
				c ^= otp_fuse_pkg::ecc_code[i];
		return {c, d};
	endfunction

	initial begin
		{rst_b_i, reg_wr_i, reg_rd_i, reg_page_i, reg_addr_i, reg_wdata_i, reload_start_i} = '0;
		{reload_fuse_latch_i, reload_shadow_i} = 2'b11;
		{ecc_enable_i, cfg_rd_bank_i, redundant_load_bits_i} = '0;
		n_mismatch = 0;
		total_checks = 0;
		void'($urandom(13));
		repeat (8) @(posedge mclk_i);
		#1 rst_b_i = 1'b1;
		wait_done();
		flags_chk('0, '0);
		rchk(2'h1, 8'h80, 8'h00);
		rchk(2'h0, 8'h0e, 8'h00);
		rchk(2'h0, 8'h0f, 8'h01);
		rchk(2'h0, 8'h55, 8'h00);
		for (int b = 0; b < nb; b++) begin
			v = (b == 0) ? 8'hff : 8'($urandom);
			wr(2'h2, 8'hc0 + 8'(b), v);
			chk("bias pin", v[3], bias_o[b]);
			chk("program pin", v[1], prog_o[b]);
			chk("strobe pin", v[2], strobe_o[b]);
			rchk(2'h2, 8'hc0 + 8'(b), {4'h0, v[3:0]});
			wr(2'h2, 8'hc0 + 8'(b), 8'h00);
		end
		wr(2'h1, 8'h80, 8'hff);
		rchk(2'h1, 8'h80, 8'h01);
		wr(2'h1, 8'h80, 8'h00);
		// clean, single, double and check-bit faults across the banks
		for (int b = 0; b < nb; b++) begin
			kind[b] = (b == 9) ? 3 : b % 3;
			dat[b] = 20'($urandom);
			w = enc(dat[b]);
			if (kind[b] == 1 || kind[b] == 2)
				w.data[b] ^= 1'b1;
			if (kind[b] == 2)
				w.data[b + 5] ^= 1'b1;
			if (kind[b] == 3)
				w.check[0] ^= 1'b1;
			raw[b] = w.data;
			se[b] = kind[b] == 1 || kind[b] == 3;
			de[b] = kind[b] == 2;
			if (kind[b] == 2)
				dat[b] = w.data;
			i_cells.put(b, w);
		end
		ecc_enable_i = '1; // correction enabled after clean checks
		reload(3'b001);
		flags_chk(se, de);
		rchk(2'h0, 8'h0e, 8'h01);
		chk("irq masked", 0, irq_o);
		wr(2'h0, 8'h0f, 8'h00);
		chk("irq open", 1, irq_o);
		cfg_chk(1'b0);
		wr(2'h1, 8'h80, 8'h01);
		cfg_chk(1'b1);
		wr(2'h1, 8'h80, 8'h00);
		wr(2'h2, 8'hc1, 8'h01);
		tick(1);
		chk("config shadow", dat[1], config_o[1]);
		wr(2'h2, 8'hc1, 8'h00);
		tick(1);
		chk("config latch", raw[1], config_o[1]);
		wr(2'h0, 8'h0e, 8'h01);
		rchk(2'h0, 8'h0e, 8'h00);
		chk("irq cleared", 0, irq_o);
		// no load permitted: flags stay
		ecc_enable_i = '0;
		reload(3'b011);
		flags_chk(se, de);
		// correction off: raw copied, flags cleared
		reload(3'b111);
		flags_chk('0, '0);
		for (int b = 0; b < nb; b++)
			dat[b] = raw[b];
		cfg_chk(1'b0);
		// strobe ignored without bias, captured with it
		i_cells.put(3, enc(20'h5a5a5));
		wr(2'h2, 8'hc3, 8'h04);
		wr(2'h2, 8'hc3, 8'h00);
		chk("strobe no bias", raw[3], config_o[3]);
		wr(2'h2, 8'hc3, 8'h08);
		wr(2'h2, 8'hc3, 8'h0c);
		tick(1);
		chk("strobe capture", 20'h5a5a5, config_o[3]);
		// each reload bit alone
		i_cells.put(3, enc(20'h0f0f0));
		dat[3] = 20'h5a5a5;
		{reload_fuse_latch_i, reload_shadow_i} = 2'b01;
		reload(3'b111);
		chk("shadow only reload", 20'h5a5a5, config_o[3]);
		{reload_fuse_latch_i, reload_shadow_i} = 2'b10;
		reload(3'b111);
		chk("latch only reload", 20'h0f0f0, config_o[3]);
		cfg_chk(1'b0);
		stop_test();
	end
endmodule
